// ---- hdl/fmt_pkg.sv ----
package fmt_pkg;

  // ==========================================================================
  // widths and link timing
  localparam int SAMPLE_W        = 16;
  localparam int IN_W            = 18;
  localparam int CHANNELS        = 2;
  localparam int LANES_PER_CH    = 2;
  localparam int BITS_PER_CYCLE  = 4;   // two lanes, two edges each
  localparam int FRAME_CYCLES    = SAMPLE_W / BITS_PER_CYCLE;
  localparam int MAX_LANE_MBPS   = 1000;
  localparam int MIN_SAMPLE_MSPS = 20;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_TEST_MODE  = 8'h0D;
  localparam logic [7:0] ADDR_OUT_MODE   = 8'h14;
  localparam logic [7:0] ADDR_OUT_PHASE  = 8'h16;
  localparam logic [7:0] ADDR_USER_W1A   = 8'h19;
  localparam logic [7:0] ADDR_USER_W1B   = 8'h1A;
  localparam logic [7:0] ADDR_USER_W2A   = 8'h1B;
  localparam logic [7:0] ADDR_USER_W2B   = 8'h1C;
  localparam logic [7:0] ADDR_SER_CTRL   = 8'h21;
  localparam logic [7:0] ADDR_STATUS     = 8'h22;

  // ==========================================================================
  // field positions and reset values
  localparam int TM_PN_SHORT_RST_BIT = 4;
  localparam int TM_PN_LONG_RST_BIT  = 5;
  localparam int OM_OFFSET_BIN_BIT   = 0;
  localparam int OM_REDUCED_BIT      = 1;
  localparam int SC_LSB_FIRST_BIT    = 0;
  localparam int SC_TRIM_LSB         = 1;
  localparam logic [3:0] PHASE_RST   = 4'h3;   // 3 x 30 deg = 90 deg
  localparam logic [2:0] TRIM_MAX    = 3'h4;   // 16 down to 12 bits

  // ==========================================================================
  // test mode codes
  localparam logic [3:0] MODE_OFF         = 4'h0;
  localparam logic [3:0] MODE_MIDSCALE    = 4'h1;
  localparam logic [3:0] MODE_FULL_POS    = 4'h2;
  localparam logic [3:0] MODE_FULL_NEG    = 4'h3;
  localparam logic [3:0] MODE_CHECKER     = 4'h4;
  localparam logic [3:0] MODE_PN_LONG     = 4'h5;
  localparam logic [3:0] MODE_PN_SHORT    = 4'h6;
  localparam logic [3:0] MODE_WORD_TOGGLE = 4'h7;
  localparam logic [3:0] MODE_USER        = 4'h8;
  localparam logic [3:0] MODE_BIT_TOGGLE  = 4'h9;
  localparam logic [3:0] MODE_SYNC        = 4'hA;
  localparam logic [3:0] MODE_ONE_HIGH    = 4'hB;
  localparam logic [3:0] MODE_MIXED       = 4'hC;

  // ==========================================================================
  // pattern words in offset binary form, saturation limits TC_MAX and TC_MIN in twos complement
  localparam logic [15:0] PAT_MID    = 16'h8000;
  localparam logic [15:0] PAT_FULL   = 16'hFFFF;
  localparam logic [15:0] PAT_ZERO   = 16'h0000;
  localparam logic [15:0] PAT_CHK1   = 16'hAAAA;
  localparam logic [15:0] PAT_CHK2   = 16'h5555;
  localparam logic [15:0] PAT_SYNC   = 16'h00FF;
  localparam logic [15:0] PAT_MIXED  = 16'hA19C;
  localparam logic [15:0] TC_MAX     = 16'h7FFF;
  localparam logic [15:0] TC_MIN     = 16'h8000;
  localparam logic [15:0] PN_SHORT_FIRST = 16'hFF83;

  // pseudorandom generators: length and tap index
  localparam int PN_SHORT_LEN = 9;
  localparam int PN_SHORT_TAP = 4;
  localparam int PN_LONG_LEN  = 23;
  localparam int PN_LONG_TAP  = 17;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic rise;
    logic fall;
  } ddr_pair_s;

  typedef struct packed {
    logic [3:0]       mode;
    logic             pn_short_rst;
    logic             pn_long_rst;
    logic             offset_bin;
    logic             reduced;
    logic [3:0]       phase;
    logic             lsb_first;
    logic [2:0]       trim;
    logic [3:0][7:0]  user;
    logic             req_s1;
    logic             req_s2;
    logic             ack;
    logic             sel;
    logic [3:0]       last_mode;
    logic [8:0]       pn_short;
    logic [22:0]      pn_long;
    logic [1:0][15:0] hold;
    logic [7:0]       rdata;
  } core_state_s;

  typedef struct packed {
    logic                 rs1;
    logic                 rs2;
    logic                 ack_s1;
    logic                 ack_s2;
    logic                 req;
    logic [1:0]           cnt;
    logic [1:0][15:0]     sh;
    logic [1:0][15:0]     last;
    ddr_pair_s [3:0]      lane;
    ddr_pair_s            word_frame_clock_out;
    ddr_pair_s            bit_rate_clock_out;
  } link_state_s;

endpackage

// ---- hdl/adc_serial_output_formatter.sv ----
`timescale 1ns/1ps
// How it works
// - twos complement default, offset binary selectable
// - each channel split over two DDR lanes
// - lane rate up to 1 Gbps, sample rate at least 20 MSPS
// - data clock runs at four times sample
// - frame clock marks each word start
// - data clock phase programmable in 30 degree steps
// - reference data clock phase is ninety degrees
// - MSB first by default, LSB first selectable
// - reduced drive mode selectable
// - sample coding saturates at full scale
// - mode codes 1 to 7 select patterns
// - mode codes 8 to 12 select patterns
// - two-word patterns alternate per sample
// - only some patterns follow output format
// - user pattern alternates two programmed words
// - non-random patterns trim to 12-16 bits
// - short random pattern x9+x5+1, all ones seed
// - short random words MSB first, top aligned
// - long random pattern x23+x18+1, all ones seed
// - test mode replaces converter samples
// - bits 4 and 5 reseed random generators
module adc_serial_output_formatter #(
  parameter int IN_W = fmt_pkg::IN_W
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        link_clk_i,
  input  wire logic [1:0][IN_W-1:0]        sample_i,
  input  wire logic [7:0]                  cfg_addr_i,
  input  wire logic [7:0]                  cfg_wdata_i,
  input  wire logic                        cfg_we_i,
  output logic [7:0]                       cfg_rdata_o,
  output logic                             reduced_drive_o,
  output logic [3:0]                       bit_rate_clock_phase_o,
  output fmt_pkg::ddr_pair_s               bit_rate_clock_out_o,
  output fmt_pkg::ddr_pair_s               word_frame_clock_out_o,
  output fmt_pkg::ddr_pair_s [3:0]         data_lane_o
);

  // ==========================================================================
  // saturation limits at input width
  localparam logic signed [IN_W-1:0] SAT_HI = {{(IN_W-16){1'b0}}, fmt_pkg::TC_MAX};
  localparam logic signed [IN_W-1:0] SAT_LO = {{(IN_W-16){1'b1}}, fmt_pkg::TC_MIN};

  fmt_pkg::core_state_s c;
  fmt_pkg::core_state_s cn;
  fmt_pkg::link_state_s l;
  fmt_pkg::link_state_s ln;
  logic                 gen;

  // runs a generator sixteen steps, returns {word, state}
  function automatic logic [38:0] pn_run(input logic [22:0] seed, input int len,
                                         input int tap);
    logic [22:0] st;
    logic [15:0] w;
    logic        nb;
    st = seed;
    w  = '0;
    nb = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      w[15-i] = st[len-1];
      nb      = st[len-1] ^ st[tap];
      st      = {st[21:0], nb};
    end
    return {w, st};
  endfunction

  // ==========================================================================
  // core domain: registers and word generation
  always_comb
  begin
    logic [38:0]            pn_s;
    logic [38:0]            pn_l;
    logic signed [IN_W-1:0] sx;
    logic [15:0]            sat;
    logic [15:0]            raw;
    logic [15:0]            word;
    logic                   fmt_on;
    logic                   trim_ok;
    logic                   s;
    pn_s    = pn_run({14'h0000, c.pn_short}, fmt_pkg::PN_SHORT_LEN, fmt_pkg::PN_SHORT_TAP);
    pn_l    = pn_run(c.pn_long, fmt_pkg::PN_LONG_LEN, fmt_pkg::PN_LONG_TAP);
    sx      = '0;
    sat     = '0;
    raw     = '0;
    word    = '0;
    fmt_on  = 1'b1;
    trim_ok = 1'b0;
    s       = 1'b0;
    cn      = c;
    gen     = c.req_s2 != c.ack;

    // register writes
    if (cfg_we_i)
    begin
      if (cfg_addr_i == fmt_pkg::ADDR_TEST_MODE)
      begin
        cn.mode         = cfg_wdata_i[3:0];
        cn.pn_short_rst = cfg_wdata_i[fmt_pkg::TM_PN_SHORT_RST_BIT];
        cn.pn_long_rst  = cfg_wdata_i[fmt_pkg::TM_PN_LONG_RST_BIT];
      end
      else if (cfg_addr_i == fmt_pkg::ADDR_OUT_MODE)
      begin
        cn.offset_bin = cfg_wdata_i[fmt_pkg::OM_OFFSET_BIN_BIT];
        cn.reduced    = cfg_wdata_i[fmt_pkg::OM_REDUCED_BIT];
      end
      else if (cfg_addr_i == fmt_pkg::ADDR_OUT_PHASE)
        cn.phase = cfg_wdata_i[3:0];
      else if (cfg_addr_i == fmt_pkg::ADDR_USER_W1A)
        cn.user[0] = cfg_wdata_i;
      else if (cfg_addr_i == fmt_pkg::ADDR_USER_W1B)
        cn.user[1] = cfg_wdata_i;
      else if (cfg_addr_i == fmt_pkg::ADDR_USER_W2A)
        cn.user[2] = cfg_wdata_i;
      else if (cfg_addr_i == fmt_pkg::ADDR_USER_W2B)
        cn.user[3] = cfg_wdata_i;
      else if (cfg_addr_i == fmt_pkg::ADDR_SER_CTRL)
      begin
        cn.lsb_first = cfg_wdata_i[fmt_pkg::SC_LSB_FIRST_BIT];
        cn.trim      = (cfg_wdata_i[3:1] > fmt_pkg::TRIM_MAX) ? fmt_pkg::TRIM_MAX
                                                              : cfg_wdata_i[3:1];
      end
    end

    // read mux, unmapped reads zero
    if (cfg_addr_i == fmt_pkg::ADDR_TEST_MODE)
      cn.rdata = {2'b00, c.pn_long_rst, c.pn_short_rst, c.mode};
    else if (cfg_addr_i == fmt_pkg::ADDR_OUT_MODE)
      cn.rdata = {6'h00, c.reduced, c.offset_bin};
    else if (cfg_addr_i == fmt_pkg::ADDR_OUT_PHASE)
      cn.rdata = {4'h0, c.phase};
    else if (cfg_addr_i == fmt_pkg::ADDR_USER_W1A)
      cn.rdata = c.user[0];
    else if (cfg_addr_i == fmt_pkg::ADDR_USER_W1B)
      cn.rdata = c.user[1];
    else if (cfg_addr_i == fmt_pkg::ADDR_USER_W2A)
      cn.rdata = c.user[2];
    else if (cfg_addr_i == fmt_pkg::ADDR_USER_W2B)
      cn.rdata = c.user[3];
    else if (cfg_addr_i == fmt_pkg::ADDR_SER_CTRL)
      cn.rdata = {4'h0, c.trim, c.lsb_first};
    else if (cfg_addr_i == fmt_pkg::ADDR_STATUS)
      cn.rdata = {6'h00, gen, c.sel};
    else
      cn.rdata = 8'h00;

    // word request from link domain
    cn.req_s1 = l.req;
    cn.req_s2 = c.req_s1;

    // one whole word per request, settings sampled together
    if (gen)
    begin
      s = (c.mode != c.last_mode) ? 1'b0 : c.sel;
      for (int ch = 0; ch < fmt_pkg::CHANNELS; ch++)
      begin
        sx = $signed(sample_i[ch]);
        if (sx > SAT_HI)
          sat = fmt_pkg::TC_MAX;
        else if (sx < SAT_LO)
          sat = fmt_pkg::TC_MIN;
        else
          sat = sx[15:0];
        // only samples, fixed levels and random words follow the coding
        fmt_on = (c.mode < fmt_pkg::MODE_CHECKER) || (c.mode == fmt_pkg::MODE_PN_LONG) ||
                 (c.mode == fmt_pkg::MODE_PN_SHORT) || (c.mode > fmt_pkg::MODE_MIXED);
        case (c.mode)
          fmt_pkg::MODE_MIDSCALE:    raw = fmt_pkg::PAT_MID;
          fmt_pkg::MODE_FULL_POS:    raw = fmt_pkg::PAT_FULL;
          fmt_pkg::MODE_FULL_NEG:    raw = fmt_pkg::PAT_ZERO;
          fmt_pkg::MODE_PN_LONG:     raw = pn_l[38:23];
          fmt_pkg::MODE_PN_SHORT:    raw = pn_s[38:23];
          fmt_pkg::MODE_CHECKER:     raw = s ? fmt_pkg::PAT_CHK2 : fmt_pkg::PAT_CHK1;
          fmt_pkg::MODE_WORD_TOGGLE: raw = s ? fmt_pkg::PAT_ZERO : fmt_pkg::PAT_FULL;
          fmt_pkg::MODE_USER:
            raw = s ? {c.user[3], c.user[2]} : {c.user[1], c.user[0]};
          fmt_pkg::MODE_BIT_TOGGLE:  raw = fmt_pkg::PAT_CHK1;
          fmt_pkg::MODE_SYNC:        raw = fmt_pkg::PAT_SYNC;
          fmt_pkg::MODE_ONE_HIGH:    raw = fmt_pkg::PAT_MID;
          fmt_pkg::MODE_MIXED:       raw = fmt_pkg::PAT_MIXED;
          default:                   raw = {~sat[15], sat[14:0]};
        endcase
        word    = (fmt_on && !c.offset_bin) ? {~raw[15], raw[14:0]} : raw;
        trim_ok = (c.mode != fmt_pkg::MODE_OFF) && (c.mode != fmt_pkg::MODE_PN_LONG) &&
                  (c.mode != fmt_pkg::MODE_PN_SHORT) && (c.mode <= fmt_pkg::MODE_MIXED);
        if (trim_ok)
          word = word & 16'(16'hFFFF << c.trim);
        if (c.lsb_first)
          word = {<<{word}};
        cn.hold[ch] = word;
      end
      cn.sel       = ~s;
      cn.last_mode = c.mode;
      cn.ack       = ~c.ack;
      if (c.mode == fmt_pkg::MODE_PN_SHORT)
        cn.pn_short = pn_s[8:0];
      if (c.mode == fmt_pkg::MODE_PN_LONG)
        cn.pn_long = pn_l[22:0];
    end

    // reseed wins over advance
    if (c.pn_short_rst)
      cn.pn_short = '1;
    if (c.pn_long_rst)
      cn.pn_long = '1;
  end

  // core state register, synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      c       <= '0;
      c.phase <= fmt_pkg::PHASE_RST;
      c.pn_short <= '1;
      c.pn_long  <= '1;
    end
    else
      c <= cn;
  end

  // ==========================================================================
  // link domain: serialiser on the bit-rate clock
  always_comb
  begin
    logic [1:0][15:0] w;
    w         = l.sh;
    ln        = l;
    ln.rs1    = rstn_i;
    ln.rs2    = l.rs1;
    ln.ack_s1 = c.ack;
    ln.ack_s2 = l.ack_s1;
    ln.cnt    = 2'(l.cnt + 2'd1);

    // frame boundary: take a fresh word if the handshake is done
    if (l.cnt == 2'(fmt_pkg::FRAME_CYCLES - 1))
    begin
      if (l.ack_s2 == l.req)
      begin
        w       = c.hold;
        ln.last = c.hold;
        ln.req  = ~l.req;
      end
      else
        w = l.last;
    end

    // two lanes per channel, one bit per edge
    for (int ch = 0; ch < fmt_pkg::CHANNELS; ch++)
    begin
      ln.lane[2*ch].rise   = w[ch][15];
      ln.lane[2*ch].fall   = w[ch][13];
      ln.lane[2*ch+1].rise = w[ch][14];
      ln.lane[2*ch+1].fall = w[ch][12];
      ln.sh[ch]            = 16'(w[ch] << fmt_pkg::BITS_PER_CYCLE);
    end
    ln.word_frame_clock_out.rise = ln.cnt < 2'd2;
    ln.word_frame_clock_out.fall = ln.cnt < 2'd2;
    ln.bit_rate_clock_out.rise = 1'b1;
    ln.bit_rate_clock_out.fall = 1'b0;

    // reset held until synchronised release
    if (!l.rs2)
    begin
      ln.req  = 1'b0;
      ln.cnt  = 2'(fmt_pkg::FRAME_CYCLES - 1);
      ln.sh   = '0;
      ln.last = '0;
      ln.lane = '0;
      ln.word_frame_clock_out  = '0;
      ln.bit_rate_clock_out  = '0;
    end
  end

  // link state register
  always_ff @(posedge link_clk_i)
  begin
    l <= ln;
  end

  // ==========================================================================
  // outputs straight from flops
  assign cfg_rdata_o            = c.rdata;
  assign reduced_drive_o        = c.reduced;
  assign bit_rate_clock_phase_o = c.phase;
  assign bit_rate_clock_out_o   = l.bit_rate_clock_out;
  assign word_frame_clock_out_o = l.word_frame_clock_out;
  assign data_lane_o            = l.lane;

  // ==========================================================================
  // checks
  sequence s_user_gen;
    gen && c.mode == fmt_pkg::MODE_USER && c.last_mode == fmt_pkg::MODE_USER &&
    !c.lsb_first && c.trim == 3'h0;
  endsequence

  sequence s_frame_high;
    l.word_frame_clock_out.rise [*2];
  endsequence

  AST_TWOS_DEFAULT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> !c.offset_bin && c.phase == fmt_pkg::PHASE_RST)
    else $error("coding or phase not at default after reset");

  AST_SATURATE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gen && c.mode == fmt_pkg::MODE_OFF && !c.offset_bin && !c.lsb_first &&
    $signed(sample_i[0]) > SAT_HI |=> c.hold[0] == fmt_pkg::TC_MAX)
    else $error("over-range sample not saturated");

  AST_MIDSCALE_FMT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gen && c.mode == fmt_pkg::MODE_MIDSCALE && !c.offset_bin && !c.lsb_first
    |=> c.hold[0] == fmt_pkg::PAT_ZERO && c.hold[1] == fmt_pkg::PAT_ZERO)
    else $error("midscale not converted to twos complement");

  AST_USER_ALT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_user_gen |=> c.hold[0] == ($past(c.sel) ? {c.user[3], c.user[2]}
                                              : {c.user[1], c.user[0]}) && c.sel != $past(c.sel))
    else $error("user words do not alternate");

  AST_LSB_FIRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gen && c.mode == fmt_pkg::MODE_MIXED && c.lsb_first && c.trim == 3'h0
    |=> c.hold[0][15] == fmt_pkg::PAT_MIXED[0] && c.hold[0][12] == fmt_pkg::PAT_MIXED[3] &&
        c.hold[0][0] == fmt_pkg::PAT_MIXED[15])
    else $error("bit order not reversed");

  AST_PN_SEED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    c.pn_short_rst || c.pn_long_rst
    |=> (!$past(c.pn_short_rst) || c.pn_short == 9'h1FF) &&
        (!$past(c.pn_long_rst) || c.pn_long == 23'h7FFFFF))
    else $error("generator not reseeded");

  AST_PN_FIRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gen && c.mode == fmt_pkg::MODE_PN_SHORT && c.pn_short == 9'h1FF && !c.lsb_first
    |=> c.hold[0] == ($past(c.offset_bin) ? fmt_pkg::PN_SHORT_FIRST
                                          : {~fmt_pkg::PN_SHORT_FIRST[15],
                                             fmt_pkg::PN_SHORT_FIRST[14:0]}))
    else $error("short random first word wrong");

  AST_TRIM: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gen && c.mode == fmt_pkg::MODE_MIXED && !c.lsb_first && c.trim == fmt_pkg::TRIM_MAX
    |=> c.hold[0] == {fmt_pkg::PAT_MIXED[15:4], 4'h0})
    else $error("twelve-bit trim wrong");

  AST_HOLD_ON_ACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(c.hold) |-> $changed(c.ack))
    else $error("word changed outside handshake");

  AST_FRAME_CLK: assert property (@(posedge link_clk_i) disable iff (!l.rs2)
    $rose(l.word_frame_clock_out.rise) |-> s_frame_high ##1 (!l.word_frame_clock_out.rise) [*2])
    else $error("frame clock not two high two low");

  AST_LANE_ORDER: assert property (@(posedge link_clk_i) disable iff (!l.rs2)
    l.cnt == 2'd1 |-> l.lane[0].rise == $past(l.sh[0][15]) &&
                      l.lane[1].fall == $past(l.sh[0][12]))
    else $error("lane bit order wrong");

endmodule

// ---- tb/lane_receiver.sv ----
`timescale 1ns/1ps
// far-end deserialiser rebuilding words from both edges of each lane
module lane_receiver (
  input  wire logic                     link_clk_i,
  input  wire logic                     rstn_i,
  input  wire fmt_pkg::ddr_pair_s       dco_i,
  input  wire fmt_pkg::ddr_pair_s       fco_i,
  input  wire fmt_pkg::ddr_pair_s [3:0] lane_i,
  output logic [1:0][15:0]              word_o,
  output int                            word_cnt_o,
  output logic                          frame_err_o
);
  logic [1:0][15:0] sh;
  logic [1:0][15:0] nx;
  logic [1:0]       cnt;
  logic             fco_q;
  logic             run;
  // ==========================================================================
  // four bits per channel per cycle: rise of both lanes, then fall
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      nx[c] = {sh[c][11:0], lane_i[2*c].rise, lane_i[2*c+1].rise,
               lane_i[2*c].fall, lane_i[2*c+1].fall};
    end
  end
  // frame tracking, word capture, clock shape watch
  always_ff @(posedge link_clk_i)
  begin
    if (!rstn_i)
    begin
      cnt <= 2'h0;
      fco_q <= 1'b0;
      run <= 1'b0;
      word_o <= '0;
      word_cnt_o <= 0;
      frame_err_o <= 1'b0;
    end
    else
    begin
      sh <= nx;
      fco_q <= fco_i.rise;
      cnt <= (fco_i.rise && !fco_q) ? 2'h1 : cnt + 2'h1;
      if (fco_i.rise && !fco_q)
        run <= 1'b1;
      if (run && cnt == 2'h3)
      begin
        word_o <= nx;
        word_cnt_o <= word_cnt_o + 1;
      end
      if (run && (dco_i !== 2'b10 || fco_i.fall !== fco_i.rise || fco_i.rise !== (cnt < 2'h2)))
        frame_err_o <= 1'b1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic                     clk_i;
  logic                     link_clk_i;
  logic                     rstn_i;
  logic [1:0][17:0]         sample_i;
  logic [7:0]               cfg_addr_i;
  logic [7:0]               cfg_wdata_i;
  logic                     cfg_we_i;
  logic [7:0]               cfg_rdata_o;
  logic                     reduced_drive_o;
  logic [3:0]               bit_rate_clock_phase_o;
  fmt_pkg::ddr_pair_s       bit_rate_clock_out;
  fmt_pkg::ddr_pair_s       word_frame_clock_out;
  fmt_pkg::ddr_pair_s [3:0] lane;
  logic [1:0][15:0]         word;
  logic                     frame_err;
  int                       word_cnt;
  int                       last_cnt;
  int                       n_mismatch;
  int                       n_checks;
  logic [15:0]              w0;
  logic [15:0]              w1;

  adc_serial_output_formatter i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i),
    .sample_i(sample_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_we_i(cfg_we_i), .cfg_rdata_o(cfg_rdata_o), .reduced_drive_o(reduced_drive_o),
    .bit_rate_clock_phase_o(bit_rate_clock_phase_o), .bit_rate_clock_out_o(bit_rate_clock_out),
    .word_frame_clock_out_o(word_frame_clock_out), .data_lane_o(lane));
  lane_receiver i_rx (.link_clk_i(link_clk_i), .rstn_i(rstn_i), .dco_i(bit_rate_clock_out), .fco_i(word_frame_clock_out),
    .lane_i(lane), .word_o(word), .word_cnt_o(word_cnt), .frame_err_o(frame_err));

  // ==========================================================================
  // clocks; link rate far under the lane limit, phase unrelated
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end
  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_we_i <= 1'b1;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    cfg_addr_i <= a;
    @(posedge clk_i);
    #1;
  endtask
  task automatic get_word();
    int i;
    i = 0;
    while (word_cnt == last_cnt && i < 200)
    begin
      @(posedge clk_i);
      i++;
    end
    if (i == 200)
      check("word_arrival", 16'h0001, 16'h0000);
    last_cnt = word_cnt;
    w0 = word[0];
    w1 = word[1];
  endtask
  task automatic flush();
    repeat (6) get_word();
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    check("phase_rst", 16'h0003, {12'h0, bit_rate_clock_phase_o});
    wr(fmt_pkg::ADDR_OUT_PHASE, 8'h05);
    rd(fmt_pkg::ADDR_OUT_PHASE);
    check("phase_rd", 16'h0005, {8'h0, cfg_rdata_o});
    check("phase_out", 16'h0005, {12'h0, bit_rate_clock_phase_o});
    check("drive_rst", 16'h0000, {15'h0, reduced_drive_o});
    wr(fmt_pkg::ADDR_OUT_MODE, 8'h02);
    rd(8'h00);
    check("unmapped", 16'h0000, {8'h0, cfg_rdata_o});
    check("drive_set", 16'h0001, {15'h0, reduced_drive_o});
    wr(fmt_pkg::ADDR_OUT_MODE, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_fixed();
    logic [3:0]  md [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hC};
    logic [15:0] tc [7] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hAAAA, 16'h00FF, 16'h8000, 16'hA19C};
    logic [15:0] ob [7] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'h00FF, 16'h8000, 16'hA19C};
    sample_i <= {18'h01234, 18'h01234}; // live samples must not leak into patterns
    for (int f = 0; f < 2; f++)
    begin
      wr(fmt_pkg::ADDR_OUT_MODE, 8'(f));
      for (int i = 0; i < 7; i++)
      begin
        wr(fmt_pkg::ADDR_TEST_MODE, {4'h0, md[i]});
        flush();
        check("fixed_ch0", f ? ob[i] : tc[i], w0);
        check("fixed_ch1", f ? ob[i] : tc[i], w1);
      end
    end
    wr(fmt_pkg::ADDR_OUT_MODE, 8'h00);
    $display("t_fixed done");
  endtask
  task automatic t_alt();
    logic [15:0] a [3]  = '{16'hAAAA, 16'hFFFF, 16'hA55A};
    logic [15:0] b [3]  = '{16'h5555, 16'h0000, 16'h3CC3};
    logic [3:0]  md [3] = '{4'h4, 4'h7, 4'h8};
    int          na;
    int          nb;
    int          nx;
    wr(fmt_pkg::ADDR_USER_W1A, 8'h5A);
    wr(fmt_pkg::ADDR_USER_W1B, 8'hA5);
    wr(fmt_pkg::ADDR_USER_W2A, 8'hC3);
    wr(fmt_pkg::ADDR_USER_W2B, 8'h3C);
    rd(fmt_pkg::ADDR_USER_W2A);
    check("user_rd", 16'h00C3, {8'h0, cfg_rdata_o});
    for (int i = 0; i < 3; i++)
    begin
      wr(fmt_pkg::ADDR_TEST_MODE, {4'h0, md[i]});
      flush();
      na = 0;
      nb = 0;
      nx = 0;
      repeat (16)
      begin
        get_word();
        if (w0 === a[i]) na++;
        else if (w0 === b[i]) nb++;
        else nx++;
      end
      check("alt_other", 16'h0000, 16'(nx));
      check("alt_first", 16'h0001, {15'h0, na != 0});
      check("alt_second", 16'h0001, {15'h0, nb != 0});
    end
    $display("t_alt done");
  endtask
  task automatic t_samples();
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h00);
    sample_i <= {18'h20000, 18'h1FFFF};
    for (int f = 0; f < 2; f++)
    begin
      wr(fmt_pkg::ADDR_OUT_MODE, 8'(f));
      flush();
      check("sat_top", f ? 16'hFFFF : 16'h7FFF, w0);
      check("sat_bottom", f ? 16'h0000 : 16'h8000, w1);
    end
    wr(fmt_pkg::ADDR_OUT_MODE, 8'h00);
    $display("t_samples done");
  endtask
  task automatic t_order();
    wr(fmt_pkg::ADDR_TEST_MODE, {4'h0, fmt_pkg::MODE_MIXED});
    wr(fmt_pkg::ADDR_SER_CTRL, 8'h01);
    flush();
    check("lsb_first", 16'h3985, w0);
    wr(fmt_pkg::ADDR_SER_CTRL, 8'h08);
    flush();
    check("trim12", 16'hA190, w0);
    wr(fmt_pkg::ADDR_SER_CTRL, 8'h00);
    $display("t_order done");
  endtask
  task automatic t_pn();
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h16);
    flush();
    check("short_seed", 16'h7F83, w0);
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h06);
    for (int i = 0; i < 10 && w0 === 16'h7F83; i++) get_word();
    check("short_next", 16'h5F17, w0);
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h16);
    flush();
    check("short_reseed", 16'h7F83, w0);
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h25);
    flush();
    check("long_seed", 16'h7FFF, w0);
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h05);
    for (int i = 0; i < 10 && w0 === 16'h7FFF; i++) get_word();
    check("long_next", 16'h7E00, w0);
    wr(fmt_pkg::ADDR_TEST_MODE, 8'h25);
    flush();
    check("long_reseed", 16'h7FFF, w0);
    check("frame_shape", 16'h0000, {15'h0, frame_err});
    $display("t_pn done");
  endtask
  // ==========================================================================
  // verdict, watchdog and main sequence
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #900000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    rstn_i = 1'b0;
    cfg_we_i = 1'b0;
    cfg_addr_i = 8'h00;
    cfg_wdata_i = 8'h00;
    sample_i = '0;
    last_cnt = 0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_fixed();
    t_alt();
    t_samples();
    t_order();
    t_pn();
    give_verdict();
  end
endmodule
